// *** rtl/tmp_map.vh ***
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Temperatures are signed 16-bit values in units of 0.1 degC
// Notes:   Included by the supervisor design file only, not by the timer or hysteresis blocks
`ifndef TMP_MAP_VH
`define TMP_MAP_VH

// Register byte offsets on the APB slave
`define TMP_OFS_CTRL        12'h000
`define TMP_OFS_COMFORT     12'h004
`define TMP_OFS_BAND        12'h008
`define TMP_OFS_ATTEN       12'h00C
`define TMP_OFS_MIX         12'h010
`define TMP_OFS_SURF_LIM    12'h014
`define TMP_OFS_WIN_DELAY   12'h018
`define TMP_OFS_EXT_TMO     12'h01C
`define TMP_OFS_STATUS      12'h020
`define TMP_OFS_TEMP_EFF    12'h024
`define TMP_OFS_SETPOINT    12'h028

// Control register fields
`define TMP_CTRL_AUTO       0
`define TMP_CTRL_INTEG      1
`define TMP_CTRL_WEIGHT     2
`define TMP_CTRL_WIN        3
`define TMP_CTRL_WIN2       4
`define TMP_CTRL_SURF       5
`define TMP_CTRL_ACOND      6
`define TMP_CTRL_LOCKINV    7
`define TMP_CTRL_COOLBUS    8
`define TMP_CTRL_MASK       16'h01FF

// Status register fields
`define TMP_ST_COOLING      0
`define TMP_ST_STOP         1
`define TMP_ST_LOCK         2
`define TMP_ST_FAULT        3
`define TMP_ST_TIMEOUT      4
`define TMP_ST_SURF         5
`define TMP_ST_ACOND        6
`define TMP_ST_WINDOW       7
`define TMP_ST_MODE_LO      8

// Operating mode codes
`define TMP_MODE_COMFORT    2'h0
`define TMP_MODE_STANDBY    2'h1
`define TMP_MODE_ECONOMY    2'h2
`define TMP_MODE_PROTECT    2'h3

// Reset values
`define TMP_RST_CTRL        16'h0002
`define TMP_RST_COMFORT     16'h00D2
`define TMP_RST_BAND        16'h0014
`define TMP_RST_STANDBY     8'h14
`define TMP_RST_ECONOMY     8'h28
`define TMP_RST_PROTECT     8'h8C
`define TMP_RST_MIX         5'h10
`define TMP_MIX_FULL        5'h10
`define TMP_RST_SURF_LIM    16'h0122
`define TMP_SURF_HYST       16'h0003
`define TMP_RST_WIN_DELAY   16'h003C
`define TMP_RST_EXT_TMO     16'h012C

// Plausibility limits of the internal sensor reading
`define TMP_SENSOR_LOW      16'hFED4
`define TMP_SENSOR_HIGH     16'h0320

// Timing: one supervision tick, in milliseconds and clock period in ns
`define TMP_TICK_MS         1000
`define TMP_CLK_NS          4
`define TMP_TICK_CYCLES     ((`TMP_TICK_MS * 1000000) / `TMP_CLK_NS)

`endif

// *** rtl/tmp_timer.v ***
// Purpose: Tick counter that reports when a running condition outlasts a limit
// Assumes: tick is a one-cycle pulse from the supervisor prescaler
// Notes:   Saturates instead of wrapping so a long condition stays expired
`timescale 1ns/1ps
`default_nettype none
module tmp_timer (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        tick,
   input  wire        run,
   input  wire        restart,
   input  wire [15:0] limit,
   output wire        expired
);
   reg [15:0] count;

   // Count ticks while running; dropping run or a restart clears it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 16'h0000;
      end else if (!run || restart) begin
         count <= 16'h0000;
      end else if (tick && (count != 16'hFFFF) && (count <= limit)) begin
         count <= count + 16'h0001;
      end
   end

   // Strictly past the limit: the first tick may land one cycle after start
   assign expired = run && !restart && (count > limit);
endmodule // tmp_timer
`default_nettype wire

// *** rtl/tmp_hyst.v ***
// Purpose: Over-limit trip with release below limit minus hysteresis
// Assumes: value and limit share the same signed 0.1 degC scale
// Notes:   Between the two thresholds the trip simply holds
`timescale 1ns/1ps
`default_nettype none
module tmp_hyst (
   input  wire               clk,
   input  wire               rst_n,
   input  wire               enable,
   input  wire signed [15:0] value,
   input  wire signed [15:0] limit,
   input  wire signed [15:0] hyst,
   output reg                trip
);
   wire signed [15:0] release_lvl;

   assign release_lvl = limit - hyst;

   // Set above the limit, clear once well below it or when disabled
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trip <= 1'b0;
      end else if (!enable) begin
         trip <= 1'b0;
      end else if (value > limit) begin
         trip <= 1'b1;
      end else if (value < release_lvl) begin
         trip <= 1'b0;
      end
   end
endmodule // tmp_hyst
`default_nettype wire

// *** rtl/tmp_supervisor.v ***
// Purpose: Supervisory logic of a room thermostat behind an APB register file
// Assumes: All bus objects arrive as levels or one-cycle pulses on pclk
// Notes:   The PI output itself is computed elsewhere and only gated here
`timescale 1ns/1ps
`default_nettype none
`include "tmp_map.vh"
module tmp_supervisor #(
   parameter [31:0] TICK_CYCLES = `TMP_TICK_CYCLES
) (
   input  wire               pclk,
   input  wire               presetn,
   input  wire               psel,
   input  wire               penable,
   input  wire               pwrite,
   input  wire [11:0]        paddr,
   input  wire [31:0]        pwdata,
   output reg  [31:0]        prdata,
   output wire               pready,
   output wire               pslverr,
   input  wire signed [15:0] room_temp_int,
   input  wire               ntc_res_high,
   input  wire               ntc_res_low,
   input  wire signed [15:0] ext_temp,
   input  wire               ext_temp_valid,
   input  wire signed [15:0] surface_temp,
   input  wire               surface_temp_valid,
   input  wire               generator_lock,
   input  wire               anticond_alarm,
   input  wire               window_a_open,
   input  wire               window_b_open,
   input  wire [1:0]         scheduled_mode,
   input  wire               presence_mode_valid,
   input  wire [1:0]         presence_mode,
   input  wire               supervisor_forced_valid,
   input  wire [1:0]         supervisor_forced_mode_input,
   input  wire               demand_on,
   input  wire [7:0]         demand_pct,
   output reg                valve_on,
   output reg  [7:0]         valve_pct,
   output reg                intercept_close,
   output reg                control_stop_alarm,
   output reg                cooling_mode,
   output reg  [3:0]         active_mode_onehot,
   output reg  [1:0]         active_mode,
   output reg  signed [15:0] room_temp_eff,
   output reg  signed [15:0] active_heat_sp,
   output reg  signed [15:0] active_cool_sp
);
   // Software-visible configuration
   reg        [15:0] ctrl;
   reg signed [15:0] comfort_heat;
   reg        [15:0] dead_band;
   reg        [7:0]  att_standby;
   reg        [7:0]  att_economy;
   reg        [7:0]  att_protect;
   reg        [4:0]  mix_ratio;
   reg signed [15:0] surf_limit;
   reg        [15:0] win_delay;
   reg        [15:0] ext_timeout;
   // Internal state
   reg signed [15:0] surf_value;
   reg        [31:0] tick_cnt;
   reg               tick;
   reg        [15:0] status_word;

   wire        setup_ph;
   wire        wr_en;
   wire        auto_sw;
   reg         mapped;
   reg  [31:0] next_prdata;

   // APB answers in the first access cycle; never stalls
   assign pready   = 1'b1;
   assign setup_ph = psel && !penable;
   assign wr_en    = psel && penable && pwrite;
   assign pslverr  = psel && penable && !mapped;
   assign auto_sw  = ctrl[`TMP_CTRL_AUTO];

   // Address decode for the error answer; read capture has its own case
   always @* begin
      case (paddr)
         `TMP_OFS_CTRL, `TMP_OFS_COMFORT, `TMP_OFS_BAND, `TMP_OFS_ATTEN,
         `TMP_OFS_MIX, `TMP_OFS_SURF_LIM, `TMP_OFS_WIN_DELAY,
         `TMP_OFS_EXT_TMO, `TMP_OFS_STATUS, `TMP_OFS_TEMP_EFF,
         `TMP_OFS_SETPOINT: mapped = 1'b1;
         default:           mapped = 1'b0;
      endcase
   end

   // Register writes; band and attenuations lock while auto switchover runs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl         <= `TMP_RST_CTRL;
         comfort_heat <= `TMP_RST_COMFORT;
         dead_band    <= `TMP_RST_BAND;
         att_standby  <= `TMP_RST_STANDBY;
         att_economy  <= `TMP_RST_ECONOMY;
         att_protect  <= `TMP_RST_PROTECT;
         mix_ratio    <= `TMP_RST_MIX;
         surf_limit   <= `TMP_RST_SURF_LIM;
         win_delay    <= `TMP_RST_WIN_DELAY;
         ext_timeout  <= `TMP_RST_EXT_TMO;
      end else if (wr_en) begin
         case (paddr)
            `TMP_OFS_CTRL:      ctrl <= pwdata[15:0] & `TMP_CTRL_MASK;
            `TMP_OFS_COMFORT:   comfort_heat <= pwdata[15:0];
            `TMP_OFS_BAND: begin
               if (!auto_sw) begin
                  dead_band <= pwdata[15:0];
               end
            end
            `TMP_OFS_ATTEN: begin
               if (!auto_sw) begin
                  att_standby <= pwdata[7:0];
                  att_economy <= pwdata[15:8];
                  att_protect <= pwdata[23:16];
               end
            end
            `TMP_OFS_MIX:       mix_ratio <= pwdata[4:0];
            `TMP_OFS_SURF_LIM:  surf_limit <= pwdata[15:0];
            `TMP_OFS_WIN_DELAY: win_delay <= pwdata[15:0];
            `TMP_OFS_EXT_TMO:   ext_timeout <= pwdata[15:0];
            default: begin
            end
         endcase
      end
   end

   // Read data captured in the setup cycle, so prdata leaves a flip-flop
   always @* begin
      case (paddr)
         `TMP_OFS_CTRL:      next_prdata = {16'h0000, ctrl};
         `TMP_OFS_COMFORT:   next_prdata = {16'h0000, comfort_heat};
         `TMP_OFS_BAND:      next_prdata = {16'h0000, dead_band};
         `TMP_OFS_ATTEN:     next_prdata = {8'h00, att_protect, att_economy, att_standby};
         `TMP_OFS_MIX:       next_prdata = {27'h000_0000, mix_ratio};
         `TMP_OFS_SURF_LIM:  next_prdata = {16'h0000, surf_limit};
         `TMP_OFS_WIN_DELAY: next_prdata = {16'h0000, win_delay};
         `TMP_OFS_EXT_TMO:   next_prdata = {16'h0000, ext_timeout};
         `TMP_OFS_STATUS:    next_prdata = {16'h0000, status_word};
         `TMP_OFS_TEMP_EFF:  next_prdata = {16'h0000, room_temp_eff};
         `TMP_OFS_SETPOINT:  next_prdata = {active_cool_sp, active_heat_sp};
         default:            next_prdata = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // Supervision tick prescaler; slow timers run on it, not on pclk
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b0;
      end else if (tick_cnt >= TICK_CYCLES - 32'h0000_0001) begin
         tick_cnt <= 32'h0000_0000;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
         tick     <= 1'b0;
      end
   end

   // Weighted room temperature; ratio is the internal share in sixteenths
   wire        [4:0]  r_int;
   wire        [4:0]  r_ext;
   wire signed [21:0] prod_int;
   wire signed [21:0] prod_ext;
   wire signed [21:0] mix_sum;
   wire signed [15:0] next_temp_eff;

   assign r_int    = (mix_ratio > `TMP_MIX_FULL) ? `TMP_MIX_FULL : mix_ratio;
   assign r_ext    = `TMP_MIX_FULL - r_int;
   assign prod_int = room_temp_int * $signed({1'b0, r_int});
   assign prod_ext = ext_temp * $signed({1'b0, r_ext});
   assign mix_sum  = prod_int + prod_ext;
   assign next_temp_eff = ctrl[`TMP_CTRL_WEIGHT] ? mix_sum[19:4] : room_temp_int;

   // Stop causes; the alarm drops only when none is left
   wire lock_act;
   wire sens_low;
   wire sens_high;
   wire sens_fault;
   wire ext_stale;
   wire stop_now;

   assign lock_act   = generator_lock ^ ctrl[`TMP_CTRL_LOCKINV];
   assign sens_low   = room_temp_int < $signed(`TMP_SENSOR_LOW);
   assign sens_high  = room_temp_int > $signed(`TMP_SENSOR_HIGH);
   assign sens_fault = (sens_low && ntc_res_high) || (sens_high && ntc_res_low);
   assign stop_now   = lock_act || sens_fault || ext_stale;

   // External value must be refreshed within the timeout
   tmp_timer u_ext_timer (
      .clk     (pclk),
      .rst_n   (presetn),
      .tick    (tick),
      .run     (ctrl[`TMP_CTRL_WEIGHT]),
      .restart (ext_temp_valid),
      .limit   (ext_timeout),
      .expired (ext_stale)
   );

   // Surface temperature latched from the bus object
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         surf_value <= 16'h0000;
      end else if (surface_temp_valid) begin
         surf_value <= surface_temp;
      end
   end

   wire surf_trip;

   tmp_hyst u_surf_limit (
      .clk    (pclk),
      .rst_n  (presetn),
      .enable (ctrl[`TMP_CTRL_SURF]),
      .value  (surf_value),
      .limit  (surf_limit),
      .hyst   (`TMP_SURF_HYST),
      .trip   (surf_trip)
   );

   // Window contacts; a delay filters out short openings
   wire win_enable;
   wire win_raw;
   wire win_forced;

   assign win_enable = ctrl[`TMP_CTRL_WIN] && ctrl[`TMP_CTRL_INTEG];
   assign win_raw    = win_enable &&
                       (window_a_open || (ctrl[`TMP_CTRL_WIN2] && window_b_open));

   tmp_timer u_win_timer (
      .clk     (pclk),
      .rst_n   (presetn),
      .tick    (tick),
      .run     (win_raw),
      .restart (1'b0),
      .limit   (win_delay),
      .expired (win_forced)
   );

   // Mode resolution: window, then supervisor, then presence, then schedule
   reg [1:0] next_mode;

   always @* begin
      if (win_forced) begin
         next_mode = `TMP_MODE_PROTECT;
      end else if (supervisor_forced_valid) begin
         next_mode = supervisor_forced_mode_input;
      end else if (presence_mode_valid) begin
         next_mode = presence_mode;
      end else begin
         next_mode = scheduled_mode;
      end
   end

   // Setpoints follow comfort heating, so one write moves them all
   reg         [7:0]  att_sel;
   wire signed [15:0] next_heat_sp;
   wire signed [15:0] next_cool_sp;

   always @* begin
      case (next_mode)
         `TMP_MODE_COMFORT: att_sel = 8'h00;
         `TMP_MODE_STANDBY: att_sel = att_standby;
         `TMP_MODE_ECONOMY: att_sel = att_economy;
         `TMP_MODE_PROTECT: att_sel = att_protect;
         default:           att_sel = 8'h00;
      endcase
   end

   assign next_heat_sp = comfort_heat - $signed({8'h00, att_sel});
   assign next_cool_sp = comfort_heat + $signed(dead_band) + $signed({8'h00, att_sel});

   // Heating/cooling choice with dead band memory
   reg next_cooling;

   always @* begin
      if (!auto_sw) begin
         next_cooling = ctrl[`TMP_CTRL_COOLBUS];
      end else if (room_temp_eff < active_heat_sp) begin
         next_cooling = 1'b0;
      end else if (room_temp_eff > active_cool_sp) begin
         next_cooling = 1'b1;
      end else begin
         next_cooling = cooling_mode;
      end
   end

   // Valve gating; anticondensation needs cooling and a live demand
   wire demanding;
   wire acond_close;
   wire next_intercept;
   wire hold_closed;

   assign demanding      = demand_on || (demand_pct != 8'h00);
   assign acond_close    = ctrl[`TMP_CTRL_ACOND] && anticond_alarm &&
                           cooling_mode && demanding;
   assign next_intercept = surf_trip || acond_close;
   assign hold_closed    = stop_now || next_intercept;

   // Output and state registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         room_temp_eff      <= 16'h0000;
         active_mode        <= `TMP_MODE_COMFORT;
         active_mode_onehot <= 4'b0001;
         active_heat_sp     <= `TMP_RST_COMFORT;
         active_cool_sp     <= `TMP_RST_COMFORT;
         cooling_mode       <= 1'b0;
         control_stop_alarm <= 1'b0;
         intercept_close    <= 1'b0;
         valve_on           <= 1'b0;
         valve_pct          <= 8'h00;
      end else begin
         room_temp_eff      <= next_temp_eff;
         active_mode        <= next_mode;
         active_mode_onehot <= 4'b0001 << next_mode;
         active_heat_sp     <= next_heat_sp;
         active_cool_sp     <= next_cool_sp;
         cooling_mode       <= next_cooling;
         control_stop_alarm <= stop_now;
         intercept_close    <= next_intercept;
         valve_on           <= hold_closed ? 1'b0 : demand_on;
         valve_pct          <= hold_closed ? 8'h00 : demand_pct;
      end
   end

   // Status snapshot for software
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_word <= 16'h0000;
      end else begin
         status_word <= {6'h00, active_mode, win_forced, acond_close, surf_trip,
                         ext_stale, sens_fault, lock_act, control_stop_alarm,
                         cooling_mode};
      end
   end
endmodule // tmp_supervisor
`default_nettype wire

// *** testbench/tmp_supervisor_properties.sv ***
// Purpose: Port-level properties of the thermostat supervisor
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Config bits are internal, so rules are checked where ports suffice
`timescale 1ns/1ps
`default_nettype none
module tmp_supervisor_checker (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic signed [15:0] room_temp_int,
   input wire logic               ntc_res_high,
   input wire logic               ntc_res_low,
   input wire logic               window_a_open,
   input wire logic               window_b_open,
   input wire logic [1:0]         scheduled_mode,
   input wire logic               presence_mode_valid,
   input wire logic [1:0]         presence_mode,
   input wire logic               supervisor_forced_valid,
   input wire logic [1:0]         supervisor_forced_mode_input,
   input wire logic               demand_on,
   input wire logic               valve_on,
   input wire logic [7:0]         valve_pct,
   input wire logic               control_stop_alarm,
   input wire logic               intercept_close,
   input wire logic               cooling_mode,
   input wire logic [3:0]         active_mode_onehot,
   input wire logic [1:0]         active_mode,
   input wire logic signed [15:0] active_heat_sp,
   input wire logic signed [15:0] active_cool_sp
);
   logic quiet;

   // No window open, so mode priority falls to the other sources
   assign quiet = !window_a_open && !window_b_open;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_stop_close; control_stop_alarm |-> !valve_on && valve_pct == 8'h00; endproperty
   a_stop_close: assert property (p_stop_close) else $error("valve open while stopped");
   property p_valve_gate; valve_on |-> $past(demand_on); endproperty
   a_valve_gate: assert property (p_valve_gate) else $error("valve on without demand");
   property p_fault_stop;
      (room_temp_int < -16'sd300 && ntc_res_high) || (room_temp_int > 16'sd800 && ntc_res_low)
         |=> control_stop_alarm;
   endproperty
   a_fault_stop: assert property (p_fault_stop) else $error("sensor fault not stopped");
   property p_onehot; active_mode_onehot == (4'b0001 << active_mode); endproperty
   a_onehot: assert property (p_onehot) else $error("mode vector not one-hot");
   property p_sp_order; active_cool_sp >= active_heat_sp; endproperty
   a_sp_order: assert property (p_sp_order) else $error("setpoints crossed");
   property p_sched;
      quiet && !supervisor_forced_valid && !presence_mode_valid
         |=> active_mode == $past(scheduled_mode);
   endproperty
   a_sched: assert property (p_sched) else $error("scheduled mode not restored");
   property p_forced; quiet && supervisor_forced_valid
      |=> active_mode == $past(supervisor_forced_mode_input); endproperty
   a_forced: assert property (p_forced) else $error("forced mode ignored");
   property p_presence; quiet && !supervisor_forced_valid && presence_mode_valid
      |=> active_mode == $past(presence_mode); endproperty
   a_presence: assert property (p_presence) else $error("presence mode ignored");

   // Main scenarios reached
   c_stop: cover property ($rose(control_stop_alarm));
   c_protect: cover property (active_mode == 2'h3);
   c_icept: cover property ($rose(intercept_close));
   c_cool: cover property ($rose(cooling_mode));
endmodule // tmp_supervisor_checker

bind tmp_supervisor tmp_supervisor_checker u_tmp_supervisor_checker (.*);
`default_nettype wire

// *** testbench/tmp_bus_peer.sv ***
// Purpose: Other bus devices sending temperature objects
// Assumes: Telegrams arrive every fourth pclk cycle
// Notes:   Surface value is only valid in its pulse cycle
`timescale 1ns/1ps
`default_nettype none
module tmp_bus_peer (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               refresh_en,
   input wire logic signed [15:0] surf_val,
   output logic                   ext_temp_valid,
   output logic                   surface_temp_valid,
   output logic signed [15:0]     surface_temp
);
   logic [1:0] cnt;

   // Outside its pulse the line shows the inverse, never a held copy
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 2'h0;
         ext_temp_valid <= 1'b0;
         surface_temp_valid <= 1'b0;
         surface_temp <= 16'h0000;
      end else begin
         cnt <= cnt + 2'h1;
         ext_temp_valid <= refresh_en && cnt == 2'h0;
         surface_temp_valid <= cnt == 2'h1;
         surface_temp <= (cnt == 2'h1) ? surf_val : ~surf_val;
      end
   end
endmodule // tmp_bus_peer
`default_nettype wire

// *** testbench/tmp_supervisor_tb.sv ***
// Purpose: Self-checking bench of the thermostat supervisor
// Assumes: TICK_CYCLES shortened to 4, so one tick is 4 pclk cycles
// Notes:   Inputs change at rising edges, outputs are read at falling edges, except prdata and pslverr, which apb reads right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module tmp_supervisor_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, refresh_en;
   logic ntc_res_high, ntc_res_low, ext_temp_valid, surface_temp_valid, generator_lock;
   logic anticond_alarm, window_a_open, window_b_open, presence_mode_valid, demand_on;
   logic supervisor_forced_valid, valve_on, intercept_close, control_stop_alarm, cooling_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] scheduled_mode, presence_mode, supervisor_forced_mode_input, active_mode;
   logic [7:0] demand_pct, valve_pct;
   logic [3:0] active_mode_onehot;
   logic signed [15:0] room_temp_int, ext_temp, surface_temp, room_temp_eff, surf_val;
   logic signed [15:0] active_heat_sp, active_cool_sp;
   int err_count, cmp_count;
   // Rows: sched, presence valid/mode, forced valid/mode, expected mode
   logic [9:0] rows [7] = '{10'h000, 10'h101, 10'h280, 10'h0D5, 10'h303, 10'h1FA, 10'h0C2};
   logic [15:0] att [4] = '{16'h0000, 16'h0014, 16'h0028, 16'h008C};
   logic [31:0] rv [8] = '{32'h0000_0002, 32'h0000_00D2, 32'h0000_0014, 32'h008C_2814,
                           32'h0000_0010, 32'h0000_0122, 32'h0000_003C, 32'h0000_012C};

   tmp_supervisor #(.TICK_CYCLES(32'h0000_0004)) u_tmp_supervisor (.*);
   tmp_bus_peer u_tmp_bus_peer (.*);

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Wait n edges, then settle to the falling edge
   task automatic at(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rt(input logic signed [15:0] v, input logic e);
      @(posedge pclk);
      room_temp_int <= v;
      at(3);
      chk(cooling_mode, e);
   endtask

   task automatic sf(input logic signed [15:0] v, input logic e);
      @(posedge pclk);
      surf_val <= v;
      at(10);
      chk(intercept_close, e);
   endtask

   task automatic end_of_test;
      if (err_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      #100000;
      err_count++;
      end_of_test();
   end

   initial begin
      {presetn, psel, penable, pwrite, ntc_res_high, ntc_res_low, generator_lock} = '0;
      {anticond_alarm, window_a_open, window_b_open, presence_mode_valid} = '0;
      {supervisor_forced_valid, scheduled_mode, presence_mode, supervisor_forced_mode_input} = '0;
      {paddr, pwdata} = '0;
      {refresh_en, demand_on, demand_pct} = {2'b11, 8'h32};
      {room_temp_int, ext_temp, surf_val} = {16'h00C8, 16'h00DC, 16'h00C8};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk(rd, rv[i]);
      end
      apb(1'b1, 12'h02C, 32'h0000_0001);
      chk(er, 1'b1);
      for (int i = 0; i < 7; i++) begin
         @(posedge pclk);
         {scheduled_mode, presence_mode_valid, presence_mode, supervisor_forced_valid,
          supervisor_forced_mode_input} <= rows[i][9:2];
         at(3);
         chk(active_mode, rows[i][1:0]);
         chk(active_heat_sp, 16'h00D2 - att[rows[i][1:0]]);
      end
      @(posedge pclk);
      {scheduled_mode, presence_mode_valid, supervisor_forced_valid} <= '0;
      generator_lock <= 1'b1;
      at(3);
      chk(control_stop_alarm, 1'b1);
      chk(valve_pct, 8'h00);
      chk(valve_on, 1'b0);
      @(posedge pclk);
      {room_temp_int, ntc_res_high, generator_lock} <= {-16'sd301, 2'b10};
      at(3);
      chk(control_stop_alarm, 1'b1);
      @(posedge pclk);
      {room_temp_int, ntc_res_high} <= {16'h00C8, 1'b0};
      at(3);
      chk(control_stop_alarm, 1'b0);
      chk(valve_pct, 8'h32);
      chk(valve_on, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0082);
      at(2);
      chk(control_stop_alarm, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0006);
      apb(1'b1, 12'h010, 32'h0000_0008);
      apb(1'b1, 12'h01C, 32'h0000_0002);
      at(4);
      chk(room_temp_eff, 16'h00D2);
      chk(control_stop_alarm, 1'b0);
      @(posedge pclk);
      refresh_en <= 1'b0;
      at(30);
      chk(control_stop_alarm, 1'b1);
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0000_0012);
      @(posedge pclk);
      refresh_en <= 1'b1;
      at(10);
      chk(control_stop_alarm, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0003);
      rt(16'h00C8, 1'b0);
      rt(16'h00F0, 1'b1);
      rt(16'h00DC, 1'b1);
      rt(16'h00CD, 1'b0);
      apb(1'b1, 12'h008, 32'h0000_0032);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_0014);
      apb(1'b1, 12'h004, 32'h0000_00DC);
      rt(16'h00EB, 1'b0);
      chk(active_cool_sp, 16'h00F0);
      apb(1'b0, 12'h028, 32'h0);
      chk(rd, 32'h00F0_00DC);
      rt(16'h00F5, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0043);
      for (int i = 0; i < 4; i++) begin
         if (i == 2) rt(16'h00C8, 1'b0);
         @(posedge pclk);
         anticond_alarm <= !i[0];
         at(3);
         chk(intercept_close, i == 0);
      end
      apb(1'b1, 12'h000, 32'h0000_0122);
      sf(16'sd300, 1'b1);
      sf(16'sd288, 1'b1);
      sf(16'sd286, 1'b0);
      chk(cooling_mode, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_001A);
      apb(1'b1, 12'h018, 32'h0000_0002);
      @(posedge pclk);
      window_a_open <= 1'b1;
      repeat (2) @(posedge pclk);
      window_a_open <= 1'b0;
      at(2);
      chk(active_mode, 2'h0);
      @(posedge pclk);
      {window_a_open, supervisor_forced_valid, supervisor_forced_mode_input} <= 4'hD;
      at(20);
      chk(active_mode, 2'h3);
      chk(active_mode_onehot, 4'h8);
      @(posedge pclk);
      {window_a_open, window_b_open} <= 2'b01;
      at(20);
      chk(active_mode, 2'h3);
      @(posedge pclk);
      window_b_open <= 1'b0;
      at(3);
      chk(active_mode, 2'h1);
      apb(1'b1, 12'h000, 32'h0000_0018);
      @(posedge pclk);
      window_a_open <= 1'b1;
      at(20);
      chk(active_mode, 2'h1);
      end_of_test();
   end
endmodule // tmp_supervisor_tb
`default_nettype wire
